// *** pbq_pkg.sv ***
// package: constants and types of the packet buffer queue manager
// How it works
// - 192 KB of on-chip memory holds every frame; no external memory.
// - frames are fully stored before egress sends them out.
// - memory is cut into 256-byte pages; a frame takes as many as needed.
// - bytes are written while arriving; at frame end it joins each destination queue.
// - after egress reports the last copy of the frame sent, its pages go back to the free pool.
// - memory access is shared in fixed slots so nobody blocks forwarding.
// - each port keeps per-class frame lists, and each frame a page chain.
// - six classes per port share 512 queue entries; one entry per queued frame.
// - the depth limit of every class queue is programmable up to 512.
// - with QoS off only one queue per port is used.
// - per-port entry tables; each entry points at the frame's first page tag.
// - a page tag holds frame info and the next tag, one tag per page.
// - frames over 256 bytes use a chain of tags, jumbo frames included.
package pbq_pkg;
  localparam int BUF_KB = 192;
  localparam int MEM_BYTES = BUF_KB * 1024;
  localparam int PAGE_BYTES = 256;
  localparam int NUM_PAGES = MEM_BYTES / PAGE_BYTES;
  localparam int PG_W = 10;
  localparam int OFF_W = 8;
  localparam int ADR_W = PG_W + OFF_W;
  localparam int LEN_W = 14;
  localparam int NUM_TC = 6;
  localparam int TC_W = 3;
  localparam int Q_ENTRIES = 512;
  localparam int QI_W = 9;
  localparam int QC_W = 10;
  localparam int REF_W = 4;
  localparam int NUM_PORTS = 8;
  localparam int NUM_AUX = 6;
  localparam logic [1:0] SLOT_TX = 2'h1;
  localparam logic [1:0] SLOT_AUX = 2'h3;
  typedef enum logic [1:0] {PBQ_RX_IDLE, PBQ_RX_DATA, PBQ_RX_DROP} pbq_rx_t;
  typedef enum logic [1:0] {PBQ_TX_IDLE, PBQ_TX_SEND, PBQ_TX_WAIT, PBQ_TX_REL} pbq_tx_t;
endpackage

// *** pbq_top.sv ***
// file: shared page buffer with per-port egress frame lists
`timescale 1ns/1ps
module pbq_top #(
  parameter int NP = pbq_pkg::NUM_PORTS,
  parameter int NAUX = pbq_pkg::NUM_AUX
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // configuration
  input wire logic qos_en,
  input wire logic [pbq_pkg::QC_W-1:0] q_limit [pbq_pkg::NUM_TC],
  // receive handler
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_err,
  input wire logic [NP-1:0] rx_dest,
  input wire logic [pbq_pkg::TC_W-1:0] rx_tc,
  output logic rx_ready,
  output logic rx_done,
  output logic rx_drop,
  // transmit handler
  input wire logic [NP-1:0] tx_req,
  input wire logic tx_done,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic [$clog2(NP)-1:0] tx_port,
  // other memory requesters
  input wire logic [NAUX-1:0] aux_req,
  output logic [NAUX-1:0] aux_gnt
);
  import pbq_pkg::*;
  localparam int PW = $clog2(NP);
  localparam int AW = $clog2(NAUX);

  typedef struct packed {
    logic [1:0] slot;
    logic [AW-1:0] aux_rr;
    logic [NAUX-1:0] aux_gnt;
    pbq_rx_t rx_st;
    logic [PG_W-1:0] rx_head;
    logic [PG_W-1:0] rx_page;
    logic [LEN_W-1:0] rx_len;
    logic rx_ready;
    logic rx_done;
    logic rx_drop;
    logic [PG_W-1:0] free_head;
    logic [PG_W-1:0] free_n;
    logic [PG_W-1:0] fresh;
    pbq_tx_t tx_st;
    logic [PW-1:0] tx_port;
    logic [PW-1:0] tx_rr;
    logic [PG_W-1:0] tx_head;
    logic [PG_W-1:0] tx_page;
    logic [LEN_W-1:0] tx_pos;
    logic [LEN_W-1:0] tx_len;
    logic tx_valid;
    logic tx_last;
    logic [7:0] tx_data;
    logic [NP-1:0][NUM_TC-1:0][QI_W-1:0] qh;
    logic [NP-1:0][NUM_TC-1:0][QI_W-1:0] qt;
    logic [NP-1:0][NUM_TC-1:0][QC_W-1:0] qc;
    logic [NP-1:0][QI_W-1:0] qfh;
    logic [NP-1:0][QC_W-1:0] qfn;
    logic [NP-1:0][QC_W-1:0] qfr;
  } pbq_st_t;

  // pages spanned by a frame of the given length
  function automatic logic [PG_W-1:0] pbq_pages(input logic [LEN_W-1:0] len);
    pbq_pages = PG_W'(len[LEN_W-1:OFF_W]) + PG_W'(|len[OFF_W-1:0]);
  endfunction

  pbq_st_t r_reg, r_next;
  logic [1:0] rs_reg;
  logic rst_n;
  // storage: frame bytes, page tags, queue entries
  logic [7:0] mem [MEM_BYTES];
  logic [PG_W-1:0] tnext [NUM_PAGES];
  logic [PG_W-1:0] ttail [NUM_PAGES];
  logic [LEN_W-1:0] tlen [NUM_PAGES];
  logic [REF_W-1:0] tref [NUM_PAGES];
  logic [QI_W-1:0] qnext [NP][Q_ENTRIES];
  logic [PG_W-1:0] qpage [NP][Q_ENTRIES];
  // write strobes from the next-state logic
  logic mw_en;
  logic [ADR_W-1:0] mw_a;
  logic [1:0] tn_en;
  logic [PG_W-1:0] tn_a [2];
  logic [PG_W-1:0] tn_d [2];
  logic th_en;
  logic [LEN_W-1:0] th_len;
  logic tr_en;
  logic [PG_W-1:0] tr_a;
  logic [REF_W-1:0] tr_d;
  logic [NP-1:0] qn_en;
  logic [QI_W-1:0] qn_a [NP];
  logic [QI_W-1:0] qn_d [NP];
  logic [NP-1:0] qp_en;
  logic [QI_W-1:0] qp_a [NP];
  logic fr_en;
  logic [PG_W-1:0] fr_h;
  logic [PG_W-1:0] fr_t;
  logic [PG_W-1:0] fr_np;
  logic acc;

  // reset is released through two flops so every state flop leaves reset together
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rs_reg <= 2'h0;
    end else begin
      rs_reg <= {rs_reg[0], 1'b1};
    end
  end
  assign rst_n = rs_reg[1];
  assign acc = rx_valid & r_reg.rx_ready;

  always_comb begin
    logic need;
    logic have;
    logic ok;
    logic hit;
    logic [PG_W-1:0] pg;
    logic [TC_W-1:0] tc;
    logic [TC_W-1:0] t;
    logic [REF_W-1:0] cnt;
    logic [PW-1:0] p;
    logic [AW-1:0] a;
    logic [QI_W-1:0] e;
    logic [REF_W-1:0] rf;
    need = 1'b0;
    have = 1'b1;
    ok = 1'b0;
    hit = 1'b0;
    pg = r_reg.rx_page;
    tc = '0;
    t = '0;
    cnt = '0;
    p = '0;
    a = '0;
    e = '0;
    rf = '0;
    r_next = r_reg;
    mw_en = 1'b0;
    mw_a = {r_reg.rx_page, r_reg.rx_len[OFF_W-1:0]};
    tn_en = 2'h0;
    tn_a = '{default: '0};
    tn_d = '{default: '0};
    th_en = 1'b0;
    th_len = r_reg.rx_len + 1'b1;
    tr_en = 1'b0;
    tr_a = r_reg.tx_head;
    tr_d = '0;
    qn_en = '0;
    qn_a = '{default: '0};
    qn_d = '{default: '0};
    qp_en = '0;
    qp_a = '{default: '0};
    fr_en = 1'b0;
    fr_h = r_reg.rx_head;
    fr_t = r_reg.rx_page;
    fr_np = pbq_pages(r_reg.rx_len);
    r_next.rx_done = 1'b0;
    r_next.rx_drop = 1'b0;
    r_next.tx_valid = 1'b0;
    r_next.tx_last = 1'b0;
    r_next.aux_gnt = '0;
    // four-slot wheel: rx owns 0 and 2, tx owns 1, others share 3
    r_next.slot = r_reg.slot + 1'b1;
    r_next.rx_ready = ~r_next.slot[0];
    if (r_next.slot == SLOT_AUX) begin
      for (int i = 1; i <= NAUX; i++) begin
        a = AW'((int'(r_reg.aux_rr) + i) % NAUX);
        if (!hit && aux_req[a]) begin
          hit = 1'b1;
          r_next.aux_gnt[a] = 1'b1;
          r_next.aux_rr = a;
        end
      end
    end
    // receive: store bytes while the frame arrives, a fresh page every 256 bytes
    if (acc && r_reg.rx_st != PBQ_RX_DROP) begin
      need = (r_reg.rx_len[OFF_W-1:0] == '0);
      if (need) begin
        have = (r_reg.free_n != '0) || (r_reg.fresh < NUM_PAGES);
        if (r_reg.free_n != '0) begin
          pg = r_reg.free_head;
          r_next.free_head = tnext[r_reg.free_head];
          r_next.free_n = r_reg.free_n - 1'b1;
        end else if (have) begin
          pg = r_reg.fresh;
          r_next.fresh = r_reg.fresh + 1'b1;
        end
        if (have && r_reg.rx_len == '0) begin
          r_next.rx_head = pg;
        end else if (have) begin
          tn_en[0] = 1'b1;
          tn_a[0] = r_reg.rx_page;
          tn_d[0] = pg;
        end
        if (have) begin
          r_next.rx_page = pg;
        end
      end
      if (have) begin
        mw_en = 1'b1;
        mw_a = {pg, r_reg.rx_len[OFF_W-1:0]};
        r_next.rx_len = r_reg.rx_len + 1'b1;
        r_next.rx_st = PBQ_RX_DATA;
      end else begin
        r_next.rx_st = PBQ_RX_DROP;
      end
      // frame end: check room on every destination, then link it in
      if (rx_last && have) begin
        tc = !qos_en ? TC_W'(0) : (rx_tc < NUM_TC) ? rx_tc : TC_W'(NUM_TC - 1);
        ok = (rx_dest != '0) && !rx_err;
        for (int i = 0; i < NP; i++) begin
          if (rx_dest[i] && !(((r_reg.qfn[i] != '0) || (r_reg.qfr[i] < Q_ENTRIES))
              && (r_reg.qc[i][tc] < q_limit[tc]))) begin
            ok = 1'b0;
          end
        end
        if (ok) begin
          for (int i = 0; i < NP; i++) begin
            if (rx_dest[i]) begin
              cnt = cnt + 1'b1;
              e = (r_reg.qfn[i] != '0) ? r_reg.qfh[i] : r_reg.qfr[i][QI_W-1:0];
              if (r_reg.qfn[i] != '0) begin
                r_next.qfh[i] = qnext[i][r_reg.qfh[i]];
                r_next.qfn[i] = r_reg.qfn[i] - 1'b1;
              end else begin
                r_next.qfr[i] = r_reg.qfr[i] + 1'b1;
              end
              qp_en[i] = 1'b1;
              qp_a[i] = e;
              if (r_reg.qc[i][tc] == '0) begin
                r_next.qh[i][tc] = e;
              end else begin
                qn_en[i] = 1'b1;
                qn_a[i] = r_reg.qt[i][tc];
                qn_d[i] = e;
              end
              r_next.qt[i][tc] = e;
              r_next.qc[i][tc] = r_reg.qc[i][tc] + 1'b1;
            end
          end
          th_en = 1'b1;
          tr_en = 1'b1;
          tr_a = r_next.rx_head;
          tr_d = cnt;
          r_next.rx_done = 1'b1;
        end else begin
          fr_en = 1'b1;
          fr_h = r_next.rx_head;
          fr_t = pg;
          fr_np = pbq_pages(r_reg.rx_len + 1'b1);
          r_next.rx_drop = 1'b1;
        end
      end
    end
    // a dropped frame ends: give back the pages it already held
    if (acc && rx_last && (r_reg.rx_st == PBQ_RX_DROP || !have)) begin
      fr_en = (r_reg.rx_len != '0);
      r_next.rx_drop = 1'b1;
    end
    if (acc && rx_last) begin
      r_next.rx_st = PBQ_RX_IDLE;
      r_next.rx_len = '0;
    end
    // transmit: rotate over ports, highest class first, read one byte per slot
    case (r_reg.tx_st)
      PBQ_TX_IDLE: begin
        hit = 1'b0;
        if (r_reg.slot == SLOT_TX) begin
          for (int i = 1; i <= NP; i++) begin
            p = PW'((int'(r_reg.tx_rr) + i) % NP);
            if (!hit && tx_req[p] && r_reg.qc[p] != '0) begin
              hit = 1'b1;
              r_next.tx_port = p;
            end
          end
        end
        if (hit) begin
          p = r_next.tx_port;
          hit = 1'b0;
          for (int k = NUM_TC - 1; k >= 0; k--) begin
            if (!hit && r_reg.qc[p][k] != '0) begin
              hit = 1'b1;
              t = TC_W'(k);
            end
          end
          e = r_reg.qh[p][t];
          r_next.qh[p][t] = qnext[p][e];
          r_next.qc[p][t] = r_reg.qc[p][t] - 1'b1;
          qn_en[p] = 1'b1;
          qn_a[p] = e;
          qn_d[p] = r_reg.qfh[p];
          r_next.qfh[p] = e;
          r_next.qfn[p] = r_reg.qfn[p] + 1'b1;
          r_next.tx_head = qpage[p][e];
          r_next.tx_page = qpage[p][e];
          r_next.tx_len = tlen[qpage[p][e]];
          r_next.tx_pos = '0;
          r_next.tx_rr = p;
          r_next.tx_st = PBQ_TX_SEND;
        end
      end
      PBQ_TX_SEND: begin
        if (r_reg.slot == SLOT_TX) begin
          r_next.tx_valid = 1'b1;
          r_next.tx_data = mem[{r_reg.tx_page, r_reg.tx_pos[OFF_W-1:0]}];
          r_next.tx_pos = r_reg.tx_pos + 1'b1;
          if (r_reg.tx_pos[OFF_W-1:0] == 8'hff) begin
            r_next.tx_page = tnext[r_reg.tx_page];
          end
          if (r_reg.tx_pos + 1'b1 == r_reg.tx_len) begin
            r_next.tx_last = 1'b1;
            r_next.tx_st = PBQ_TX_WAIT;
          end
        end
      end
      PBQ_TX_WAIT: begin
        if (tx_done) begin
          r_next.tx_st = PBQ_TX_REL;
        end
      end
      PBQ_TX_REL: begin
        if (r_reg.slot == SLOT_TX) begin
          rf = tref[r_reg.tx_head] - 1'b1;
          tr_en = 1'b1;
          tr_d = rf;
          if (rf == '0) begin
            fr_en = 1'b1;
            fr_h = r_reg.tx_head;
            fr_t = ttail[r_reg.tx_head];
            fr_np = pbq_pages(r_reg.tx_len);
          end
          r_next.tx_st = PBQ_TX_IDLE;
        end
      end
      default: r_next.tx_st = PBQ_TX_IDLE;
    endcase
    // splice a whole chain onto the pool in one step; no walk needed
    if (fr_en) begin
      tn_en[1] = 1'b1;
      tn_a[1] = fr_t;
      tn_d[1] = r_next.free_head;
      r_next.free_head = fr_h;
      r_next.free_n = r_next.free_n + fr_np;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // memories carry no reset; fresh pages and entries are handed out by counters first
  always_ff @(posedge sys_clk) begin
    if (mw_en) begin
      mem[mw_a] <= rx_data;
    end
    for (int i = 0; i < 2; i++) begin
      if (tn_en[i]) begin
        tnext[tn_a[i]] <= tn_d[i];
      end
    end
    if (th_en) begin
      tlen[r_next.rx_head] <= th_len;
      ttail[r_next.rx_head] <= r_next.rx_page;
    end
    if (tr_en) begin
      tref[tr_a] <= tr_d;
    end
    for (int i = 0; i < NP; i++) begin
      if (qn_en[i]) begin
        qnext[i][qn_a[i]] <= qn_d[i];
      end
      if (qp_en[i]) begin
        qpage[i][qp_a[i]] <= r_next.rx_head;
      end
    end
  end

  assign rx_ready = r_reg.rx_ready;
  assign rx_done = r_reg.rx_done;
  assign rx_drop = r_reg.rx_drop;
  assign tx_valid = r_reg.tx_valid;
  assign tx_data = r_reg.tx_data;
  assign tx_last = r_reg.tx_last;
  assign tx_port = r_reg.tx_port;
  assign aux_gnt = r_reg.aux_gnt;

  default clocking pbq_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rx_end;
    acc && rx_last;
  endsequence
  sequence s_rel;
    r_reg.tx_st == PBQ_TX_REL;
  endsequence
  AST_RX_SLOT: assert property (rx_ready |-> !r_reg.slot[0]) else $error("rx ready outside rx slot");
  AST_AUX_GNT: assert property (|aux_gnt |-> $onehot(aux_gnt) && r_reg.slot == SLOT_AUX)
    else $error("aux grant bad");
  AST_TX_SLOT: assert property (tx_valid |-> $past(r_reg.slot) == SLOT_TX) else $error("tx byte off slot");
  AST_RX_END: assert property (s_rx_end |=> (rx_done ^ rx_drop)) else $error("frame end not resolved");
  AST_NO_END: assert property ((rx_done || rx_drop) |-> $past(acc && rx_last)) else $error("stray end");
  AST_TX_LAST: assert property (tx_last |-> tx_valid && r_reg.tx_st == PBQ_TX_WAIT) else $error("last bad");
  AST_WAIT: assert property ((r_reg.tx_st == PBQ_TX_WAIT && tx_done) |=> s_rel) else $error("done lost");
  AST_REL: assert property (s_rel |-> ##[1:4] r_reg.tx_st == PBQ_TX_IDLE) else $error("release stuck");
  AST_POOL: assert property (r_reg.free_n <= r_reg.fresh && r_reg.fresh <= NUM_PAGES)
    else $error("page pool count bad");
  AST_QENT: assert property (r_reg.qfn[0] <= r_reg.qfr[0] && r_reg.qfr[0] <= Q_ENTRIES)
    else $error("queue entry count bad");
endmodule

// *** pbq_mac_model.sv ***
// behavioural egress mac that collects frames and acknowledges them
`timescale 1ns/1ps
module pbq_mac_model (
  // clock
  input wire logic sys_clk,
  // egress byte stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic [2:0] tx_port,
  // acknowledge delay and acknowledge
  input wire logic [3:0] done_gap,
  output logic tx_done
);
  logic [7:0] bytes_q [$];
  logic [2:0] port_q [$];
  int len_q [$];
  int cnt = 0;
  int wait_n = 0;
  // bytes are taken on every pulse since the buffer offers no back-pressure
  always @(posedge sys_clk) begin
    tx_done <= (wait_n == 1);
    if (wait_n > 0) wait_n--;
    if (tx_valid === 1'b1) begin
      bytes_q.push_back(tx_data);
      cnt++;
      // a slow gap keeps the frame held, so pages stay busy longer
      if (tx_last === 1'b1) begin
        port_q.push_back(tx_port);
        len_q.push_back(cnt);
        cnt = 0;
        wait_n = int'(done_gap) + 1;
      end
    end
  end
endmodule

// *** pbq_top_bench.sv ***
// self-checking bench of the packet buffer queue manager
`timescale 1ns/1ps
module pbq_top_bench;
  import pbq_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic qos_en = 1'b0;
  logic [QC_W-1:0] q_limit [NUM_TC];
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_last = 1'b0;
  logic rx_err = 1'b0;
  logic [7:0] rx_dest = 8'h00;
  logic [2:0] rx_tc = 3'h0;
  logic rx_ready, rx_done, rx_drop, tx_done, tx_valid, tx_last;
  logic [7:0] tx_req = 8'hff;
  logic [7:0] tx_data;
  logic [2:0] tx_port;
  logic [5:0] aux_req = 6'h00;
  logic [5:0] aux_gnt;
  logic [3:0] done_gap = 4'h1;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  pbq_top #(.NP(8), .NAUX(6)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .qos_en(qos_en),
    .q_limit(q_limit), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_err(rx_err),
    .rx_dest(rx_dest), .rx_tc(rx_tc), .rx_ready(rx_ready), .rx_done(rx_done), .rx_drop(rx_drop),
    .tx_req(tx_req), .tx_done(tx_done), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_port(tx_port), .aux_req(aux_req), .aux_gnt(aux_gnt));
  pbq_mac_model u_mac (.sys_clk(sys_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_port(tx_port), .done_gap(done_gap), .tx_done(tx_done));

  // 100 mhz clock
  always #5 sys_clk = ~sys_clk;

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // offers one frame byte by byte, holding each until rx_ready takes it
  task automatic send(input int len, input logic [7:0] dest, input logic [2:0] tc,
    input logic err, input logic [7:0] start, input logic exp_done);
    int nd;
    int nx;
    nd = 0;
    nx = 0;
    for (int i = 0; i < len; i++) begin
      rx_valid = 1'b1;
      rx_data = start + 8'(i);
      rx_last = (i == len - 1);
      rx_dest = dest;
      rx_tc = tc;
      rx_err = err;
      @(posedge sys_clk);
      while (rx_ready !== 1'b1) @(posedge sys_clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    for (int k = 0; k < 3; k++) begin
      nd += (rx_done === 1'b1);
      nx += (rx_drop === 1'b1);
      @(posedge sys_clk);
      #1;
    end
    cmp("rx_done", 16'(exp_done), 16'(nd));
    cmp("rx_drop", 16'(!exp_done), 16'(nx));
  endtask

  task automatic wait_tx(input int n);
    for (int c = 0; c < 8000 && u_mac.len_q.size() < n; c++) @(posedge sys_clk);
    #1;
    cmp("tx_frames", 16'(n), 16'(u_mac.len_q.size()));
  endtask

  // pops one collected frame and compares length, port and every byte
  task automatic chk_frame(input logic [7:0] start, input int len, input logic [2:0] port);
    int bad;
    bad = 0;
    wait_tx(1);
    if (u_mac.len_q.size() == 0) return;
    cmp("tx_len", 16'(len), 16'(u_mac.len_q.pop_front()));
    cmp("tx_port", 16'(port), 16'(u_mac.port_q.pop_front()));
    for (int i = 0; i < len; i++) begin
      if (u_mac.bytes_q.size() == 0 || u_mac.bytes_q.pop_front() !== start + 8'(i)) bad++;
    end
    cmp("tx_bytes", 16'h0000, 16'(bad));
  endtask

  task automatic t_unicast();
    send(1, 8'h01, 3'h0, 1'b0, 8'h10, 1'b1);
    chk_frame(8'h10, 1, 3'h0);
  endtask

  // lengths at and past one page boundary, with a slow acknowledge
  task automatic t_pages();
    done_gap = 4'hc;
    send(256, 8'h02, 3'h0, 1'b0, 8'h20, 1'b1);
    chk_frame(8'h20, 256, 3'h1);
    send(700, 8'h02, 3'h0, 1'b0, 8'h30, 1'b1);
    chk_frame(8'h30, 700, 3'h1);
    done_gap = 4'h1;
  endtask

  task automatic t_mcast();
    send(5, 8'h0c, 3'h0, 1'b0, 8'h40, 1'b1);
    // the copies leave one at a time, so each wait sees exactly one new frame
    chk_frame(8'h40, 5, 3'h2);
    wait_tx(1);
    chk_frame(8'h40, 5, 3'h3);
  endtask

  task automatic t_drop();
    send(300, 8'h01, 3'h0, 1'b1, 8'h00, 1'b0);
    send(3, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0);
    repeat (40) @(posedge sys_clk);
    #1;
    cmp("tx_after_drop", 16'h0000, 16'(u_mac.len_q.size()));
  endtask

  // depth limit of one entry on a stalled port refuses the second frame
  task automatic t_limit();
    tx_req = 8'hef;
    q_limit[0] = 10'h001;
    send(4, 8'h10, 3'h0, 1'b0, 8'h60, 1'b1);
    send(4, 8'h10, 3'h0, 1'b0, 8'h70, 1'b0);
    q_limit[0] = 10'h200;
    tx_req = 8'hff;
    chk_frame(8'h60, 4, 3'h4);
  endtask

  // class order with qos on, plain arrival order with it off
  task automatic t_qos();
    qos_en = 1'b1;
    tx_req = 8'hdf;
    send(2, 8'h20, 3'h1, 1'b0, 8'h50, 1'b1);
    send(2, 8'h20, 3'h4, 1'b0, 8'h60, 1'b1);
    send(2, 8'h20, 3'h7, 1'b0, 8'h70, 1'b1);
    tx_req = 8'hff;
    chk_frame(8'h70, 2, 3'h5);
    chk_frame(8'h60, 2, 3'h5);
    chk_frame(8'h50, 2, 3'h5);
    qos_en = 1'b0;
    tx_req = 8'hdf;
    send(2, 8'h20, 3'h4, 1'b0, 8'h80, 1'b1);
    send(2, 8'h20, 3'h1, 1'b0, 8'h90, 1'b1);
    tx_req = 8'hff;
    chk_frame(8'h80, 2, 3'h5);
    chk_frame(8'h90, 2, 3'h5);
  endtask

  // all requesters waiting: one grant at a time, everyone within the wheel bound
  task automatic t_aux();
    logic [5:0] seen;
    int multi;
    seen = 6'h00;
    multi = 0;
    aux_req = 6'h3f;
    repeat (28) begin
      @(posedge sys_clk);
      #1;
      seen |= aux_gnt;
      multi += ($countones(aux_gnt) > 1);
    end
    cmp("aux_seen", 16'h003f, 16'(seen));
    cmp("aux_multi", 16'h0000, 16'(multi));
    // watch two whole wheel turns, not one sample, for a grant without request
    aux_req = 6'h00;
    seen = 6'h00;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      seen |= aux_gnt;
    end
    cmp("aux_idle", 16'h0000, 16'(seen));
  endtask

  initial begin
    foreach (q_limit[i]) q_limit[i] = 10'h200;
    repeat (5) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    t_unicast();
    t_pages();
    t_mcast();
    t_drop();
    t_limit();
    t_qos();
    t_aux();
    complete_run();
  end
endmodule
